/* core/pssup_debounce.sv */
module pssup_debounce #(
    parameter int unsigned DB_CYC = 32'h0000_0002
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin_n,
    output logic level_n,
    output logic fell
);
    logic s1_r;
    logic s2_r;
    logic lvl_r;
    logic fell_r;
    logic [31:0] cnt_r;
    wire differ = s2_r != lvl_r;
    wire done = cnt_r == DB_CYC - 32'h0000_0001;

    // Pins reset to the released level: an open input means disabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            lvl_r <= 1'b1;
            fell_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
        end else begin
            s1_r <= pin_n;
            s2_r <= s1_r;
            cnt_r <= (differ && !done) ? cnt_r + 32'h0000_0001 : 32'h0000_0000;
            if (differ && done) begin
                lvl_r <= s2_r;
            end
            fell_r <= differ && done && lvl_r;
        end
    end

    assign level_n = lvl_r;
    assign fell = fell_r;
endmodule

/* core/pssup_evt_if.sv */
interface pssup_evt_if;
    import pssup_pkg::*;
    pssup_evt_t evt;
    pssup_evt_t clr;
    pssup_evt_t en;
    pssup_evt_t status;
    logic irq;
    modport ctl (output evt, output clr, output en, input status, input irq);
    modport sink (input evt, input clr, input en, output status, output irq);
endinterface

/* core/pssup_irq.sv */
module pssup_irq (
    input wire logic core_clk,
    input wire logic rst_n,
    pssup_evt_if.sink bus
);
    import pssup_pkg::*;
    pssup_evt_t status_r;
    pssup_evt_t status_nxt;
    logic irq_r;

    // A new event in the clearing cycle is kept
    assign status_nxt = (status_r & ~bus.clr) | bus.evt;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & bus.en);
        end
    end

    assign bus.status = status_r;
    assign bus.irq = irq_r;
endmodule

/* core/pssup_params.svh */
`ifndef PSSUP_PARAMS_SVH
`define PSSUP_PARAMS_SVH

// ----------------------------------------
// Clock and time conversion
// ----------------------------------------
`define PSSUP_CLK_HZ 64'h0000_0000_02FA_F080
`define PSSUP_MS_DIV 64'h03E8
`define PSSUP_US_DIV 64'hF_4240
`define PSSUP_CEIL_MS(t) 32'((((t) * `PSSUP_CLK_HZ) + `PSSUP_MS_DIV - 64'h1) / `PSSUP_MS_DIV)
`define PSSUP_CEIL_US(t) 32'((((t) * `PSSUP_CLK_HZ) + `PSSUP_US_DIV - 64'h1) / `PSSUP_US_DIV)

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define PSSUP_PG_ON_MIN_MS 64'h0064
`define PSSUP_PG_HOLDUP_MIN_US 64'h012C
`define PSSUP_DEBOUNCE_US 64'h03E8
`define PSSUP_PG_ON_CYC `PSSUP_CEIL_MS(`PSSUP_PG_ON_MIN_MS)
`define PSSUP_HOLDUP_CYC `PSSUP_CEIL_US(`PSSUP_PG_HOLDUP_MIN_US)
`define PSSUP_DEBOUNCE_CYC `PSSUP_CEIL_US(`PSSUP_DEBOUNCE_US)

// ----------------------------------------
// Temperatures in degrees C
// ----------------------------------------
`define PSSUP_INLET_OT_C 8'h3D
`define PSSUP_INLET_OP_MAX_C 8'h37

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSSUP_REG_CTRL 8'h00
`define PSSUP_REG_STAT 8'h04
`define PSSUP_REG_FAULT 8'h08
`define PSSUP_REG_TEMP 8'h0C
`define PSSUP_REG_IRQ_STAT 8'h10
`define PSSUP_REG_IRQ_CLR 8'h14
`define PSSUP_REG_IRQ_EN 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSSUP_CTRL_CLR_BIT 0
`define PSSUP_F_OCP 0
`define PSSUP_F_SCP 1
`define PSSUP_F_OVP 2
`define PSSUP_F_UVP 3
`define PSSUP_F_GEN 4
`define PSSUP_F_COMP_OT 5
`define PSSUP_F_FAN 6
`define PSSUP_FAULT_CLEARABLE 7'h7C
`define PSSUP_E_PG_RISE 0
`define PSSUP_E_PG_FALL 1
`define PSSUP_E_SHUTDOWN 2
`define PSSUP_E_WARN 3
`define PSSUP_E_INLET_OT 4
`define PSSUP_E_FAULT_CLR 5
`define PSSUP_E_INPUT_LOST 6
`define PSSUP_E_ALERT 7

`endif

/* core/pssup_pkg.sv */
package pssup_pkg;
    typedef enum logic [1:0] {PG_OFF, PG_WAIT, PG_ON} pssup_pg_state_t;
    typedef enum logic [1:0] {OT_IDLE, OT_RAMP, OT_WARN} pssup_ot_state_t;
    typedef logic [7:0] pssup_evt_t;
    typedef logic [6:0] pssup_fault_t;
endpackage

/* core/pssup_top.sv */
// The address map and the plain strobed port are this design's own decisions.
`include "pssup_params.svh"

// Function
// [RULE1] Main output on while enable pin low, off while it is high.
// [RULE2] Enable input defaults high, so a floating pin keeps output off.
// [RULE3] Enable pin clears latched faults, but never short-circuit or over-current.
// [RULE4] Power-good high only while every output is within regulation.
// [RULE5] Power-good drops on output out of regulation or prolonged input loss.
// [RULE6] Power-good delay timer does not start while any output is current limited.
// [RULE7] Power-good driven both ways so several supplies may share one line.
// [RULE8] Alert pulled low while any shutdown or warning event is active.
// [RULE9] Events: component temperature, failure, OVER_CURRENT_PROTECTION, OVP, UVP, slow or failed fan.
// [RULE10] Alert asserts together with solid amber status indication.
// [RULE11] Inlet over-temperature warning raised at 61 C inlet air.
// [RULE12] Inlet warning clears once inlet air returns to operating range.
// [RULE13] Fan forced to maximum before the over-temperature bit is set.
// [RULE14] Short circuit on the sense inputs shuts the supply down.
// [RULE15] Presence pin held at ground; the system provides the pull-up.
// [RULE16] Power-good falls promptly after the enable pin is released.
// [RULE17] Power-good asserts 100 to 500 ms after outputs reach regulation.
// [RULE18] Enable pin synchronized, debounced; high-to-low edge clears faults.
// [RULE19] Alert released to high impedance once no event remains.
module pssup_top
    import pssup_pkg::*;
#(
    parameter int unsigned PG_ON_CYC = `PSSUP_PG_ON_CYC,
    parameter int unsigned HOLDUP_CYC = `PSSUP_HOLDUP_CYC,
    parameter int unsigned DEBOUNCE_CYC = `PSSUP_DEBOUNCE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic main_output_enable_n,
    input wire logic outputs_in_reg,
    input wire logic current_limit,
    input wire logic input_power_ok,
    input wire logic [6:0] fault_in,
    input wire logic [2:0] warn_in,
    input wire logic [7:0] inlet_temp,
    input wire logic fan_at_max,
    output logic main_output_on,
    output logic power_good_out,
    output logic power_good_oe,
    output logic fault_alert_n_o,
    output logic fault_alert_n_oe,
    output logic present_n_o,
    output logic present_n_oe,
    output logic fan_max_req,
    output logic over_temp_warning_bit,
    output logic led_amber_solid,
    output logic irq
);
    // ----------------------------------------
    // Enable pin conditioning
    // ----------------------------------------
    logic en_n_lvl;
    logic en_n_fell;

    pssup_debounce #(.DB_CYC(DEBOUNCE_CYC)) u_en_db ( // RULE18 RULE2
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_n(main_output_enable_n),
        .level_n(en_n_lvl),
        .fell(en_n_fell)
    );

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    pssup_evt_if ev ();
    pssup_evt_t irq_en_r;
    wire wr_ctrl = reg_wr && reg_addr == `PSSUP_REG_CTRL;
    wire wr_clr = reg_wr && reg_addr == `PSSUP_REG_IRQ_CLR;
    wire wr_en = reg_wr && reg_addr == `PSSUP_REG_IRQ_EN;
    wire sw_clr = wr_ctrl && reg_wdata[`PSSUP_CTRL_CLR_BIT];

    // ----------------------------------------
    // Latched shutdown faults
    // ----------------------------------------
    pssup_fault_t fault_lat_r;
    pssup_fault_t fault_lat_nxt;
    pssup_fault_t clr_mask;
    wire clr_req = en_n_fell || sw_clr;

    // Short-circuit and over-current stay latched until power is cycled
    assign clr_mask = clr_req ? `PSSUP_FAULT_CLEARABLE : 7'h00; // RULE3
    // Set wins over clear so a fault seen during clearing is not lost
    assign fault_lat_nxt = (fault_lat_r & ~clr_mask) | fault_in; // RULE9 RULE14
    wire shutdown = |fault_lat_r;
    wire main_on_nxt = !en_n_lvl && !(|fault_lat_nxt); // RULE1 RULE14

    // ----------------------------------------
    // Input loss hold-up
    // ----------------------------------------
    logic [31:0] loss_cnt_r;
    wire input_lost = loss_cnt_r == HOLDUP_CYC;
    wire [31:0] loss_cnt_nxt = input_power_ok ? 32'h0000_0000 :
                               input_lost ? loss_cnt_r : loss_cnt_r + 32'h0000_0001;

    // ----------------------------------------
    // Power-good sequencing
    // ----------------------------------------
    pssup_pg_state_t pg_st_r;
    pssup_pg_state_t pg_st_nxt;
    logic [31:0] pg_cnt_r;
    logic [31:0] pg_cnt_nxt;
    wire pg_cond = main_output_on && outputs_in_reg && !input_lost && !en_n_lvl;
    wire pg_done = pg_cnt_r == PG_ON_CYC - 32'h0000_0001;

    always_comb begin
        pg_st_nxt = pg_st_r;
        pg_cnt_nxt = 32'h0000_0000;
        case (pg_st_r)
            PG_OFF: begin
                if (pg_cond && !current_limit) begin // RULE6
                    pg_st_nxt = PG_WAIT;
                end
            end
            PG_WAIT: begin
                if (!pg_cond) begin
                    pg_st_nxt = PG_OFF;
                end else if (current_limit) begin
                    pg_cnt_nxt = 32'h0000_0000; // RULE6
                end else if (pg_done) begin
                    pg_st_nxt = PG_ON; // RULE17
                end else begin
                    pg_cnt_nxt = pg_cnt_r + 32'h0000_0001;
                end
            end
            PG_ON: begin
                if (!pg_cond) begin
                    pg_st_nxt = PG_OFF; // RULE5 RULE16
                end
            end
            default: begin
                pg_st_nxt = PG_OFF;
            end
        endcase
    end

    wire pg_nxt = pg_st_nxt == PG_ON; // RULE4

    // ----------------------------------------
    // Inlet over-temperature with fan ramp
    // ----------------------------------------
    pssup_ot_state_t ot_st_r;
    pssup_ot_state_t ot_st_nxt;
    wire inlet_hot = inlet_temp >= `PSSUP_INLET_OT_C;
    wire inlet_ok = inlet_temp <= `PSSUP_INLET_OP_MAX_C;

    always_comb begin
        ot_st_nxt = ot_st_r;
        case (ot_st_r)
            OT_IDLE: begin
                if (inlet_hot) begin
                    ot_st_nxt = OT_RAMP; // RULE11
                end
            end
            OT_RAMP: begin
                if (inlet_ok) begin
                    ot_st_nxt = OT_IDLE;
                end else if (fan_at_max) begin
                    ot_st_nxt = OT_WARN; // RULE13
                end
            end
            OT_WARN: begin
                if (inlet_ok) begin
                    ot_st_nxt = OT_IDLE; // RULE12
                end
            end
            default: begin
                ot_st_nxt = OT_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Alert and events
    // ----------------------------------------
    wire warn_any = |warn_in || over_temp_warning_bit; // RULE9
    wire alert_nxt = shutdown || warn_any; // RULE8
    pssup_evt_t evt;

    assign evt[`PSSUP_E_PG_RISE] = pg_nxt && !power_good_out;
    assign evt[`PSSUP_E_PG_FALL] = !pg_nxt && power_good_out;
    assign evt[`PSSUP_E_SHUTDOWN] = |(fault_in & ~fault_lat_r);
    assign evt[`PSSUP_E_WARN] = |warn_in && !led_amber_solid;
    assign evt[`PSSUP_E_INLET_OT] = ot_st_nxt == OT_WARN && !over_temp_warning_bit;
    assign evt[`PSSUP_E_FAULT_CLR] = clr_req && |(fault_lat_r & `PSSUP_FAULT_CLEARABLE);
    assign evt[`PSSUP_E_INPUT_LOST] = loss_cnt_nxt == HOLDUP_CYC && !input_lost;
    assign evt[`PSSUP_E_ALERT] = alert_nxt && !fault_alert_n_oe;

    assign ev.evt = evt;
    assign ev.clr = wr_clr ? reg_wdata[7:0] : 8'h00;
    assign ev.en = irq_en_r;

    pssup_irq u_irq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(ev)
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [31:0] rd_mux;
    wire [31:0] stat_word = {24'h00_0000, 1'b0, pg_st_r, ot_st_r == OT_RAMP,
                             fan_max_req, fault_alert_n_oe, main_output_on,
                             power_good_out};

    always_comb begin
        case (reg_addr)
            `PSSUP_REG_CTRL: rd_mux = 32'h0000_0000;
            `PSSUP_REG_STAT: rd_mux = stat_word;
            `PSSUP_REG_FAULT: rd_mux = {25'h000_0000, fault_lat_r};
            `PSSUP_REG_TEMP: rd_mux = {16'h0000, 7'h00, over_temp_warning_bit, inlet_temp};
            `PSSUP_REG_IRQ_STAT: rd_mux = {24'h00_0000, ev.status};
            `PSSUP_REG_IRQ_EN: rd_mux = {24'h00_0000, irq_en_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_lat_r <= 7'h00;
            loss_cnt_r <= 32'h0000_0000;
            pg_st_r <= PG_OFF;
            pg_cnt_r <= 32'h0000_0000;
            ot_st_r <= OT_IDLE;
            irq_en_r <= 8'h00;
        end else begin
            fault_lat_r <= fault_lat_nxt;
            loss_cnt_r <= loss_cnt_nxt;
            pg_st_r <= pg_st_nxt;
            pg_cnt_r <= pg_cnt_nxt;
            ot_st_r <= ot_st_nxt;
            if (wr_en) begin
                irq_en_r <= reg_wdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_output_on <= 1'b0;
            power_good_out <= 1'b0;
            power_good_oe <= 1'b0;
            fault_alert_n_oe <= 1'b0;
            led_amber_solid <= 1'b0;
            present_n_oe <= 1'b1;
            fault_alert_n_o <= 1'b0;
            present_n_o <= 1'b0;
            fan_max_req <= 1'b0;
            over_temp_warning_bit <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            main_output_on <= main_on_nxt; // RULE1
            power_good_out <= pg_nxt; // RULE4 RULE5
            // Actively driven both levels so the shared line follows the OR
            power_good_oe <= 1'b1; // RULE7
            // Alert sinks only while an event is active, floats otherwise
            fault_alert_n_oe <= alert_nxt; // RULE8 RULE19
            led_amber_solid <= alert_nxt; // RULE10
            present_n_oe <= 1'b1; // RULE15
            // Open-drain pins only ever pull low
            fault_alert_n_o <= 1'b0;
            present_n_o <= 1'b0; // RULE15
            fan_max_req <= ot_st_nxt != OT_IDLE; // RULE13
            over_temp_warning_bit <= ot_st_nxt == OT_WARN; // RULE11 RULE12
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign irq = ev.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_main_on_level: assert property (en_n_lvl |=> !main_output_on) // RULE1
        else $error("Main output on while enable is released");
    a_scp_kept: assert property ( // RULE3
        en_n_fell && fault_lat_r[`PSSUP_F_SCP] |=> fault_lat_r[`PSSUP_F_SCP])
        else $error("Short-circuit fault cleared by enable pin");
    a_ovp_cleared: assert property ( // RULE3
        en_n_fell && !fault_in[`PSSUP_F_OVP] |=> !fault_lat_r[`PSSUP_F_OVP])
        else $error("Clearable fault survived enable edge");
    a_pg_in_reg: assert property (power_good_out |-> $past(outputs_in_reg)) // RULE4
        else $error("Power-good high while outputs out of regulation");
    a_pg_drop_reg: assert property (power_good_out && !outputs_in_reg |=> !power_good_out) // RULE5
        else $error("Power-good kept after regulation loss");
    a_pg_limit_hold: assert property ( // RULE6
        pg_st_r == PG_WAIT && current_limit && pg_cond |=> pg_cnt_r == 32'h0000_0000)
        else $error("Power-good timer ran during current limit");
    a_alert_or: assert property (fault_alert_n_oe == $past(alert_nxt)) // RULE8
        else $error("Alert does not follow shutdown or warning events");
    a_alert_led: assert property (fault_alert_n_oe == led_amber_solid) // RULE10
        else $error("Alert and amber indication disagree");
    a_ot_detect: assert property (ot_st_r == OT_IDLE && inlet_hot |=> fan_max_req) // RULE11
        else $error("Inlet over-temperature not acted upon");
    a_ot_order: assert property ($rose(over_temp_warning_bit) |-> $past(fan_max_req)) // RULE13
        else $error("Over-temperature bit set before fan ramp");
    a_pg_off_en: assert property ($rose(en_n_lvl) |=> !power_good_out) // RULE16
        else $error("Power-good not dropped after enable release");
    a_pg_min_delay: assert property ( // RULE17
        $rose(power_good_out) |-> $past(pg_cnt_r) == PG_ON_CYC - 32'h0000_0001)
        else $error("Power-good asserted without full delay");

    c_pg_rise: cover property ($rose(power_good_out));
    c_alert_release: cover property ($fell(fault_alert_n_oe));
    c_ot_warn: cover property ($rose(over_temp_warning_bit));
    c_fault_clear: cover property (en_n_fell && |fault_lat_r);
endmodule

/* testbench/pssup_host_model.sv */
// ----------------------------------------
// Host side: system pull-ups and fan controller
// ----------------------------------------
module pssup_host_model #(
    parameter int unsigned FAN_DLY = 5
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic power_good_out,
    input wire logic power_good_oe,
    input wire logic fault_alert_n_o,
    input wire logic fault_alert_n_oe,
    input wire logic present_n_o,
    input wire logic present_n_oe,
    input wire logic fan_max_req,
    output logic pg_wire,
    output logic alert_wire_n,
    output logic present_wire_n,
    output logic fan_at_max
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned fan_cnt_r;

    // Released lines float up to the system pull-up, never keep the last value
    assign pg_wire = power_good_oe ? power_good_out : 1'b1;
    assign alert_wire_n = fault_alert_n_oe ? fault_alert_n_o : 1'b1;
    assign present_wire_n = present_n_oe ? present_n_o : 1'b1;

    // Fan takes FAN_DLY + 1 cycles to spin up, so the warning bit must wait for it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fan_cnt_r <= 0;
            fan_at_max <= 1'b0;
        end else if (!fan_max_req) begin
            fan_cnt_r <= 0;
            fan_at_max <= 1'b0;
        end else if (fan_cnt_r == FAN_DLY) begin
            fan_at_max <= 1'b1;
        end else begin
            fan_cnt_r <= fan_cnt_r + 1;
        end
    end
endmodule

/* testbench/psu_status_signal_supervisor_tb.sv */
module psu_status_signal_supervisor_tb;
    import pssup_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PG_ON = 20;
    localparam int unsigned HOLDUP = 8;
    localparam int unsigned DEB = 3;

    logic core_clk, rst_n, reg_wr, reg_rd, en_n, in_reg, cur_lim, pwr_ok, fan_at_max;
    logic [7:0] reg_addr, inlet_temp;
    logic [31:0] reg_wdata, reg_rdata, rd_d;
    logic [6:0] fault_in, fault_exp;
    logic [2:0] warn_in;
    logic main_on, pg_o, pg_oe, al_o, al_oe, pr_o, pr_oe, fan_req, ot_bit, amber, irq;
    logic pg_w, alert_w_n, present_w_n;
    int err_total, n_tests, n;

    always #10 core_clk = ~core_clk;

    pssup_top #(.PG_ON_CYC(PG_ON), .HOLDUP_CYC(HOLDUP), .DEBOUNCE_CYC(DEB)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .main_output_enable_n(en_n), .outputs_in_reg(in_reg), .current_limit(cur_lim),
        .input_power_ok(pwr_ok), .fault_in(fault_in), .warn_in(warn_in),
        .inlet_temp(inlet_temp), .fan_at_max(fan_at_max), .main_output_on(main_on),
        .power_good_out(pg_o), .power_good_oe(pg_oe), .fault_alert_n_o(al_o),
        .fault_alert_n_oe(al_oe), .present_n_o(pr_o), .present_n_oe(pr_oe),
        .fan_max_req(fan_req), .over_temp_warning_bit(ot_bit), .led_amber_solid(amber),
        .irq(irq));

    pssup_host_model #(.FAN_DLY(5)) host (
        .core_clk(core_clk), .rst_n(rst_n), .power_good_out(pg_o), .power_good_oe(pg_oe),
        .fault_alert_n_o(al_o), .fault_alert_n_oe(al_oe), .present_n_o(pr_o),
        .present_n_oe(pr_oe), .fan_max_req(fan_req), .pg_wire(pg_w),
        .alert_wire_n(alert_w_n), .present_wire_n(present_w_n), .fan_at_max(fan_at_max));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Long enough for two sync stages, the debounce and the output register
    task automatic set_en(input logic v);
        @(posedge core_clk);
        en_n <= v;
        tick(DEB + 6);
    endtask

    task automatic wait_pg(output int c);
        c = 0;
        while (pg_w !== 1'b1 && c < 1000) begin
            tick(1);
            c++;
        end
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
    endtask

    // Short-circuit and over-current stay latched through any clear
    function automatic logic [6:0] kept_after_clear(input logic [6:0] f);
        return f & 7'h03;
    endfunction

    task automatic print_verdict();
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        core_clk = 0;
        rst_n = 0;
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 0;
        reg_wdata = 0;
        en_n = 1;
        in_reg = 0;
        cur_lim = 0;
        pwr_ok = 1;
        fault_in = 0;
        warn_in = 0;
        inlet_temp = 8'h19;
        err_total = 0;
        n_tests = 0;
        fault_exp = 0;
        void'($urandom(32'h337f_2827));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
        check("present", present_w_n, 0);
        check("pg_idle", pg_w, 0);
        check("alert_idle", alert_w_n, 1);
        check("main_idle", main_on, 0);
        @(posedge core_clk);
        en_n <= 1'b0;
        in_reg <= 1'b1;
        cur_lim <= 1'b1;
        tick(DEB + 6);
        check("main_on", main_on, 1);
        tick(PG_ON * 2);
        check("pg_climit", pg_w, 0);
        @(posedge core_clk);
        cur_lim <= 1'b0;
        wait_pg(n);
        check("pg_delay", n >= PG_ON && n <= PG_ON + 3, 1);
        @(posedge core_clk);
        in_reg <= 1'b0;
        tick(3);
        check("pg_reg_loss", pg_w, 0);
        @(posedge core_clk);
        in_reg <= 1'b1;
        wait_pg(n);
        check("pg_back", pg_w, 1);
        @(posedge core_clk);
        pwr_ok <= 1'b0;
        tick(HOLDUP - 4);
        check("pg_holdup", pg_w, 1);
        tick(8);
        check("pg_input_lost", pg_w, 0);
        @(posedge core_clk);
        pwr_ok <= 1'b1;
        wait_pg(n);
        set_en(1'b1);
        check("pg_en_off", pg_w, 0);
        check("main_off", main_on, 0);
        set_en(1'b0);
        @(posedge core_clk);
        cur_lim <= 1'b1;
        tick(PG_ON);
        check("pg_wait_climit", pg_w, 0);
        @(posedge core_clk);
        cur_lim <= 1'b0;
        wait_pg(n);
        check("pg_restart", n >= PG_ON && n <= PG_ON + 3, 1);
        // Clearable classes first: the two sticky ones would mask the alert release
        for (int i = 6; i >= 0; i--) begin
            @(posedge core_clk);
            fault_in <= 7'h01 << i;
            inlet_temp <= 8'($urandom_range(55, 0));
            @(posedge core_clk);
            fault_in <= 7'h00;
            tick(3);
            fault_exp = fault_exp | (7'h01 << i);
            check("alert_fault", alert_w_n, 0);
            check("amber", amber, 1);
            rd(8'h08, rd_d);
            check("fault_reg", rd_d, {25'h0, fault_exp});
            if (i == 6 || (i != 5 && $urandom % 2)) wr(8'h00, 32'h0000_0001);
            else begin
                set_en(1'b1);
                set_en(1'b0);
            end
            tick(2);
            fault_exp = kept_after_clear(fault_exp);
            rd(8'h08, rd_d);
            check("fault_clr", rd_d, {25'h0, fault_exp});
            check("alert_left", alert_w_n, {31'h0, fault_exp == 7'h00});
        end
        do_reset();
        check("alert_rst", alert_w_n, 1);
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            warn_in <= 3'h1 << k;
            tick(3);
            check("alert_warn", alert_w_n, 0);
            @(posedge core_clk);
            warn_in <= 3'h0;
            tick(3);
            check("alert_rel", alert_w_n, 1);
        end
        wr(8'h18, 32'h0000_0000);
        @(posedge core_clk);
        inlet_temp <= 8'h3C;
        tick(4);
        check("fan_60c", fan_req, 0);
        @(posedge core_clk);
        inlet_temp <= 8'h3D;
        tick(3);
        check("fan_first", {fan_req, ot_bit}, 2'b10);
        tick(10);
        check("ot_set", {fan_req, ot_bit}, 2'b11);
        check("alert_ot", alert_w_n, 0);
        rd(8'h0C, rd_d);
        check("temp_reg", rd_d, 32'h0000_013D);
        rd(8'h04, rd_d);
        check("stat_reg", rd_d, 32'h0000_004F);
        check("irq_masked", irq, 0);
        rd(8'h10, rd_d);
        check("irq_stat", rd_d[4], 1);
        @(posedge core_clk);
        inlet_temp <= 8'h38;
        tick(3);
        check("ot_56c", ot_bit, 1);
        @(posedge core_clk);
        inlet_temp <= 8'h37;
        tick(3);
        check("ot_clr", {fan_req, ot_bit}, 2'b00);
        wr(8'h18, 32'h0000_0010);
        tick(1);
        check("irq_on", irq, 1);
        wr(8'h14, 32'h0000_0010);
        tick(1);
        check("irq_off", irq, 0);
        rd(8'h10, rd_d);
        check("irq_stat_clr", rd_d[4], 0);
        rd(8'h14, rd_d);
        check("clr_reads_0", rd_d, 0);
        rd(8'h1C + 8'(4 * $urandom_range(7, 0)), rd_d);
        check("unmapped", rd_d, 0);
        print_verdict();
    end
endmodule
